// File: logic/sensor_pkg.sv
// Shared constants for the sensor register slice and its host controller
package sensor_pkg;
  // Device register offsets on the serial link
  localparam logic [7:0] OFF_IRQ_MODE = 8'h06;
  localparam logic [7:0] OFF_KEY = 8'h07;
  localparam logic [7:0] OFF_WAKE = 8'h08;
  localparam logic [7:0] OFF_AMB = 8'h09;
  localparam logic [7:0] OFF_PROX = 8'h0a;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] KEY_VALUE = 8'h17;

  // Interrupt mode field positions and encodings
  localparam int CMD_MODE_LSB = 2;
  localparam int PROX3_MODE_LSB = 0;
  localparam logic [1:0] CMD_MODE_ALL = 2'h0;
  localparam logic [1:0] CMD_MODE_ERR = 2'h1;
  localparam logic [1:0] P3_MODE_DONE = 2'h0;
  localparam logic [1:0] P3_MODE_CROSS = 2'h1;
  localparam logic [1:0] P3_MODE_ABOVE = 2'h3;
  localparam int FLAG_CMD = 0;
  localparam int FLAG_P3 = 1;

  // Rate code expansion
  localparam logic [7:0] RATE_OFF = 8'h00;
  localparam logic [7:0] LOW_EXP_CODE = 8'h32;
  localparam logic [15:0] LOW_EXP_VALUE = 16'h000a;

  // Wake tick timing
  localparam real TICK_US = 31.25;
  localparam real CLK_MHZ = 40.0;
  localparam int TICK_CYCLES = int'(TICK_US * CLK_MHZ);
  localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);

  // Host controller registers on AXI4-Lite
  localparam logic [3:0] HOST_OFF_CMD = 4'h0;
  localparam logic [3:0] HOST_OFF_STATUS = 4'h4;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_IRQ_BIT = 9;
  localparam int STAT_KEY_BIT = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sensor_pkg

// File: logic/sensor_link_if.sv
// Register link and interrupt pin between host controller and sensor
`timescale 1ns/1ps
`default_nettype none
interface sensor_link_if;
  logic regWe;
  logic regRe;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regRvalid;
  logic irqO;
  logic irqOe;
  logic irqLevel;

  // Pulled-up open-drain interrupt wire
  assign irqLevel = irqOe ? irqO : 1'b1;

  modport dev (
    input regWe, regRe, regAddr, regWdata,
    output regRdata, regRvalid, irqO, irqOe
  );
  modport host (
    output regWe, regRe, regAddr, regWdata,
    input regRdata, regRvalid, irqLevel
  );
endinterface : sensor_link_if
`default_nettype wire

// File: logic/rate_expand.sv
// Expands an 8-bit compressed rate code into its 16-bit value
`timescale 1ns/1ps
`default_nettype none
module rate_expand (
  input wire logic [7:0] code,
  output logic [15:0] value
);
  // Four-bit exponent, four-bit mantissa with hidden one, scaled by 1/16
  function automatic logic [15:0] expand(input logic [7:0] c);
    logic [19:0] wide;
    wide = 20'({1'b1, c[3:0]}) << c[7:4];
    if (c == sensor_pkg::RATE_OFF) begin
      return 16'h0000;
    end else if (c == sensor_pkg::LOW_EXP_CODE) begin
      return sensor_pkg::LOW_EXP_VALUE;
    end
    return wide[19:4];
  endfunction : expand

  always_comb begin
    value = expand(code);
  end
endmodule : rate_expand
`default_nettype wire

// File: logic/sensor_regs_dev.sv
// Sensor interrupt mode, unlock key and rate registers with wake sequencer
//
// Overview of operation
// - Mode 00: every response write sets command flag
// - Mode 01: only error responses set command flag
// - Modes act only when enabled; 1x reserved
// - Prox3 mode 00: flag after each measurement
// - Prox3 mode 01: flag on threshold crossing
// - Prox3 mode 11: flag while above threshold
// - Host must write key 0x17
// - Wake interval is expanded code times 31.25us
// - Wake code 0x00 stops oscillator and measurements
// - Host never writes wake codes 0x01-0x17
// - Codes 0x84, 0x94 give 10ms, 20ms
// - Codes 0xB9, 0xDF, 0xFF give 100ms, 496ms, 1.984s
// - Ambient code expands to wake multiplier; 0 stops
// - Ambient codes 0x08, 0x32, 0x69: every 1, 10, 100
// - Proximity code expands to wake multiplier; 0 stops
// - Proximity codes 0x08, 0x32, 0x69: every 1, 10, 100
// - Host prefers large wake and small rate codes
// - All five registers reset to zero
// - Interrupt pin low on enabled flag with drive enable
`timescale 1ns/1ps
`default_nettype none
module sensor_regs_dev (
  input wire logic clk,
  input wire logic rstn,
  sensor_link_if.dev link,
  input wire logic cmdIrqEnable,
  input wire logic prox3IrqEnable,
  input wire logic intOutputEnable,
  input wire logic responseWrite,
  input wire logic [7:0] responseData,
  input wire logic prox3Done,
  input wire logic [15:0] prox3Value,
  input wire logic [15:0] prox3Threshold,
  input wire logic [1:0] flagClear,
  output logic cmdIrqFlag,
  output logic prox3IrqFlag,
  output logic unlocked,
  output logic oscRunning,
  output logic wakePulse,
  output logic ambientStart,
  output logic proxStart
);
  typedef struct packed {
    logic [1:0] commandIrqMode;
    logic [1:0] prox3IrqMode;
    logic [7:0] unlockKey;
    logic [7:0] wakePeriodCode;
    logic [7:0] ambientRateCode;
    logic [7:0] proximityRateCode;
    logic cmdFlag;
    logic p3Flag;
    logic p3Above;
    logic [10:0] tick;
    logic [15:0] wakeCnt;
    logic [15:0] ambCnt;
    logic [15:0] proxCnt;
    logic [7:0] rdata;
    logic rvalid;
    logic wake;
    logic amb;
    logic prox;
  } dev_state_t;

  dev_state_t state_r;
  dev_state_t state_nxt;
  logic [15:0] wakeValue;
  logic [15:0] ambValue;
  logic [15:0] proxValue;
  logic p3AboveNow;
  logic cmdSet;
  logic p3Set;
  logic tickWrap;
  logic wakeNow;

  rate_expand wakeExp (.code(state_r.wakePeriodCode), .value(wakeValue));
  rate_expand ambExp (.code(state_r.ambientRateCode), .value(ambValue));
  rate_expand proxExp (.code(state_r.proximityRateCode), .value(proxValue));

  // Counter reaching its expanded limit
  function automatic logic reached(input logic [15:0] cnt, input logic [15:0] lim);
    return (17'(cnt) + 17'h00001) >= 17'(lim);
  endfunction : reached

  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    state_nxt.wake = 1'b0;
    state_nxt.amb = 1'b0;
    state_nxt.prox = 1'b0;

    // Register writes from the link
    if (link.regWe) begin
      case (link.regAddr)
        sensor_pkg::OFF_IRQ_MODE: begin
          state_nxt.commandIrqMode = link.regWdata[sensor_pkg::CMD_MODE_LSB +: 2];
          state_nxt.prox3IrqMode = link.regWdata[sensor_pkg::PROX3_MODE_LSB +: 2];
        end
        sensor_pkg::OFF_KEY: begin
          state_nxt.unlockKey = link.regWdata;
        end
        sensor_pkg::OFF_WAKE: begin
          state_nxt.wakePeriodCode = link.regWdata;
        end
        sensor_pkg::OFF_AMB: begin
          state_nxt.ambientRateCode = link.regWdata;
        end
        sensor_pkg::OFF_PROX: begin
          state_nxt.proximityRateCode = link.regWdata;
        end
        default: begin
        end
      endcase
    end

    // Register reads answer one cycle later; reserved bits and holes read zero
    if (link.regRe) begin
      state_nxt.rvalid = 1'b1;
      case (link.regAddr)
        sensor_pkg::OFF_IRQ_MODE: begin
          state_nxt.rdata = {4'h0, state_r.commandIrqMode, state_r.prox3IrqMode};
        end
        sensor_pkg::OFF_KEY: begin
          state_nxt.rdata = state_r.unlockKey;
        end
        sensor_pkg::OFF_WAKE: begin
          state_nxt.rdata = state_r.wakePeriodCode;
        end
        sensor_pkg::OFF_AMB: begin
          state_nxt.rdata = state_r.ambientRateCode;
        end
        sensor_pkg::OFF_PROX: begin
          state_nxt.rdata = state_r.proximityRateCode;
        end
        default: begin
          state_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Command flag on response writes
    cmdSet = 1'b0;
    if (responseWrite && cmdIrqEnable) begin
      case (state_r.commandIrqMode)
        sensor_pkg::CMD_MODE_ALL: cmdSet = 1'b1;
        sensor_pkg::CMD_MODE_ERR: cmdSet = responseData[7];
        default: cmdSet = 1'b0;
      endcase
    end

    // Third proximity channel flag on completed measurements
    p3AboveNow = prox3Value > prox3Threshold;
    p3Set = 1'b0;
    if (prox3Done) begin
      state_nxt.p3Above = p3AboveNow;
      if (prox3IrqEnable) begin
        case (state_r.prox3IrqMode)
          sensor_pkg::P3_MODE_DONE: p3Set = 1'b1;
          sensor_pkg::P3_MODE_CROSS: p3Set = p3AboveNow != state_r.p3Above;
          sensor_pkg::P3_MODE_ABOVE: p3Set = p3AboveNow;
          default: p3Set = 1'b0;
        endcase
      end
    end

    // Sticky flags; a set in the clearing cycle wins
    state_nxt.cmdFlag = cmdSet || (state_r.cmdFlag && !flagClear[sensor_pkg::FLAG_CMD]);
    state_nxt.p3Flag = p3Set || (state_r.p3Flag && !flagClear[sensor_pkg::FLAG_P3]);

    // Wake timer: 31.25us ticks counted up to the expanded wake value
    tickWrap = state_r.tick == sensor_pkg::TICK_LAST;
    wakeNow = tickWrap && reached(state_r.wakeCnt, wakeValue);
    if (state_r.wakePeriodCode == sensor_pkg::RATE_OFF) begin
      state_nxt.tick = 11'h000;
      state_nxt.wakeCnt = 16'h0000;
      state_nxt.ambCnt = 16'h0000;
      state_nxt.proxCnt = 16'h0000;
    end else begin
      state_nxt.tick = tickWrap ? 11'h000 : state_r.tick + 11'h001;
      if (tickWrap) begin
        state_nxt.wakeCnt = wakeNow ? 16'h0000 : state_r.wakeCnt + 16'h0001;
      end
      if (wakeNow) begin
        state_nxt.wake = 1'b1;
        // Measurements on every Nth wake-up, none when the multiplier is zero
        if (ambValue != 16'h0000) begin
          state_nxt.amb = reached(state_r.ambCnt, ambValue);
          state_nxt.ambCnt = state_nxt.amb ? 16'h0000 : state_r.ambCnt + 16'h0001;
        end
        if (proxValue != 16'h0000) begin
          state_nxt.prox = reached(state_r.proxCnt, proxValue);
          state_nxt.proxCnt = state_nxt.prox ? 16'h0000 : state_r.proxCnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign link.regRdata = state_r.rdata;
  assign link.regRvalid = state_r.rvalid;
  // Open-drain interrupt: only ever pulls low
  assign link.irqO = 1'b0;
  assign link.irqOe = intOutputEnable && ((state_r.cmdFlag && cmdIrqEnable) ||
                      (state_r.p3Flag && prox3IrqEnable));
  assign cmdIrqFlag = state_r.cmdFlag;
  assign prox3IrqFlag = state_r.p3Flag;
  assign unlocked = state_r.unlockKey == sensor_pkg::KEY_VALUE;
  assign oscRunning = state_r.wakePeriodCode != sensor_pkg::RATE_OFF;
  assign wakePulse = state_r.wake;
  assign ambientStart = state_r.amb;
  assign proxStart = state_r.prox;
endmodule : sensor_regs_dev
`default_nettype wire

// File: logic/sensor_host_ctrl.sv
// Host controller: AXI4-Lite command registers driving the sensor link
`timescale 1ns/1ps
`default_nettype none
module sensor_host_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  sensor_link_if.host link
);
  typedef struct packed {
    logic awHeld;
    logic wHeld;
    logic [3:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic busy;
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wbyte;
    logic [7:0] lastRead;
  } host_state_t;

  host_state_t state_r;
  host_state_t state_nxt;
  logic doWrite;
  logic launch;

  always_comb begin
    state_nxt = state_r;
    state_nxt.we = 1'b0;
    state_nxt.re = 1'b0;

    // Address and data are taken in either order
    if (awvalid && awready) begin
      state_nxt.awHeld = 1'b1;
      state_nxt.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      state_nxt.wHeld = 1'b1;
      state_nxt.wData = wdata;
      state_nxt.wStrb = wstrb;
    end

    doWrite = state_r.awHeld && state_r.wHeld && !state_r.bValid;
    launch = doWrite && state_r.awAddr == sensor_pkg::HOST_OFF_CMD && !state_r.busy &&
             (&state_r.wStrb[2:0]);
    if (doWrite) begin
      state_nxt.awHeld = 1'b0;
      state_nxt.wHeld = 1'b0;
      state_nxt.bValid = 1'b1;
      state_nxt.bResp = (state_r.awAddr == sensor_pkg::HOST_OFF_CMD ||
                         state_r.awAddr == sensor_pkg::HOST_OFF_STATUS) ?
                        sensor_pkg::RESP_OKAY : sensor_pkg::RESP_SLVERR;
    end else if (state_r.bValid && bready) begin
      state_nxt.bValid = 1'b0;
    end

    // One link access at a time
    if (launch) begin
      state_nxt.busy = 1'b1;
      state_nxt.addr = state_r.wData[sensor_pkg::CMD_ADDR_LSB +: 8];
      state_nxt.wbyte = state_r.wData[7:0];
      state_nxt.we = state_r.wData[sensor_pkg::CMD_WRITE_BIT];
      state_nxt.re = !state_r.wData[sensor_pkg::CMD_WRITE_BIT];
    end else if (state_r.we) begin
      state_nxt.busy = 1'b0;
    end else if (link.regRvalid && state_r.busy) begin
      state_nxt.busy = 1'b0;
      state_nxt.lastRead = link.regRdata;
    end

    // Register reads
    if (arvalid && arready) begin
      state_nxt.rValid = 1'b1;
      state_nxt.rResp = sensor_pkg::RESP_OKAY;
      case (araddr)
        sensor_pkg::HOST_OFF_CMD: begin
          state_nxt.rData = {15'h0000, 1'b0, state_r.addr, state_r.wbyte};
        end
        sensor_pkg::HOST_OFF_STATUS: begin
          state_nxt.rData = 32'h00000000;
          state_nxt.rData[7:0] = state_r.lastRead;
          state_nxt.rData[sensor_pkg::STAT_BUSY_BIT] = state_r.busy;
          state_nxt.rData[sensor_pkg::STAT_IRQ_BIT] = !link.irqLevel;
          state_nxt.rData[sensor_pkg::STAT_KEY_BIT] =
            state_r.lastRead == sensor_pkg::KEY_VALUE && state_r.addr == sensor_pkg::OFF_KEY;
        end
        default: begin
          state_nxt.rData = 32'h00000000;
          state_nxt.rResp = sensor_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state_r.rValid && rready) begin
      state_nxt.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign awready = !state_r.awHeld && !state_r.bValid;
  assign wready = !state_r.wHeld && !state_r.bValid;
  assign bvalid = state_r.bValid;
  assign bresp = state_r.bResp;
  assign arready = !state_r.rValid;
  assign rvalid = state_r.rValid;
  assign rdata = state_r.rData;
  assign rresp = state_r.rResp;
  // Key 0x17 and legal codes (none in 0x01-0x17) are software's duty
  assign link.regWe = state_r.we;
  assign link.regRe = state_r.re;
  assign link.regAddr = state_r.addr;
  assign link.regWdata = state_r.wbyte;
endmodule : sensor_host_ctrl
`default_nettype wire

// File: sim/sensor_link_checker.sv
// Link protocol, register shadow and interrupt pin checks
`timescale 1ns/1ps
`default_nettype none
module sensor_link_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic regWe,
  input wire logic regRe,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid,
  input wire logic irqO,
  input wire logic irqOe,
  input wire logic irqLevel
);
  logic [7:0] shadow_r [5];
  logic [7:0] shadowVal;
  logic mapped;
  assign mapped = regAddr >= sensor_pkg::OFF_IRQ_MODE && regAddr <= sensor_pkg::OFF_PROX;
  assign shadowVal = mapped ? shadow_r[3'(regAddr - sensor_pkg::OFF_IRQ_MODE)] : 8'h00;
  // Expected register contents, upper mode bits read as zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 5; i++) shadow_r[i] <= sensor_pkg::REG_RESET;
    end else if (regWe && mapped) begin
      shadow_r[3'(regAddr - sensor_pkg::OFF_IRQ_MODE)] <=
        (regAddr == sensor_pkg::OFF_IRQ_MODE) ? (regWdata & 8'h0f) : regWdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_read; regRe && !regWe; endsequence
  sequence s_answer; regRvalid ##1 !regRvalid; endsequence
  property p_read_answer; s_read |=> s_answer; endproperty
  property p_read_value; regRe |=> regRdata == $past(shadowVal); endproperty
  property p_rdata_hold; !regRvalid |-> $stable(regRdata); endproperty
  property p_valid_cause; regRvalid |-> $past(regRe); endproperty
  property p_reset_quiet; $rose(rstn) |-> !regWe && !regRe && !regRvalid && !irqOe; endproperty
  property p_cmd_mode; regWe && regAddr == sensor_pkg::OFF_IRQ_MODE |-> !regWdata[3]; endproperty
  property p_wake_code;
    regWe && regAddr == sensor_pkg::OFF_WAKE |-> regWdata == 8'h00 || regWdata > 8'h17;
  endproperty
  property p_key; regWe && regAddr == sensor_pkg::OFF_KEY |-> regWdata == sensor_pkg::KEY_VALUE;
  endproperty
  property p_irq_pin; irqLevel != irqOe; endproperty
  property p_irq_low; irqOe |-> !irqO; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
  a_read_value: assert property (p_read_value) else $error("read value wrong");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_valid_cause: assert property (p_valid_cause) else $error("stray read answer");
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
  a_cmd_mode: assert property (p_cmd_mode) else $error("reserved mode written");
  a_wake_code: assert property (p_wake_code) else $error("illegal wake code");
  a_key: assert property (p_key) else $error("wrong key written");
  a_irq_pin: assert property (p_irq_pin) else $error("pin level wrong");
  a_irq_low: assert property (p_irq_low) else $error("pin driven high");
endmodule : sensor_link_checker
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the host controller and sensor register slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [31:0] mask; logic [31:0] val; logic [1:0] resp;} exp_t;
  localparam logic [31:0] IRQ_M = 32'h1 << sensor_pkg::STAT_IRQ_BIT;
  logic clk = 0;
  logic rstn = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic cmdIe = 0, p3Ie = 0, intOe = 0, respWr = 0, p3Done = 0;
  logic [7:0] respData = 0;
  logic [15:0] p3Value = 0, p3Thr = 16'h0064;
  logic [1:0] flagClear = 0;
  logic cmdFlag, p3Flag, unlocked, oscRunning, wakePulse, ambStart, proxStart;
  logic [31:0] lfsr = 32'hcf7e;
  int error_cnt = 0, samples_checked = 0, cycles = 0, gap = 0;
  int wakes = 0, ambs = 0, proxs = 0, stray = 0, lastGap = 0;
  exp_t expq[$];
  exp_t head;
  logic [18:0] p3Tab [7] = '{{1'b0, 2'h1, 16'h0032}, {1'b1, 2'h1, 16'h0096},
    {1'b0, 2'h1, 16'h00a0}, {1'b1, 2'h1, 16'h0028}, {1'b1, 2'h0, 16'h0028},
    {1'b0, 2'h3, 16'h0064}, {1'b1, 2'h3, 16'h0065}};
  logic [23:0] expTab [9] = '{24'h000000, 24'h080001, 24'h32000a, 24'h690064,
    24'h840140, 24'h940280, 24'hb90c80, 24'hdf3e00, 24'hfff800};

  sensor_link_if link ();
  sensor_host_ctrl i_sensor_host_ctrl (.clk(clk), .rstn(rstn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(link));
  sensor_regs_dev i_sensor_regs_dev (.clk(clk), .rstn(rstn), .link(link),
    .cmdIrqEnable(cmdIe), .prox3IrqEnable(p3Ie), .intOutputEnable(intOe),
    .responseWrite(respWr), .responseData(respData), .prox3Done(p3Done),
    .prox3Value(p3Value), .prox3Threshold(p3Thr), .flagClear(flagClear),
    .cmdIrqFlag(cmdFlag), .prox3IrqFlag(p3Flag), .unlocked(unlocked),
    .oscRunning(oscRunning), .wakePulse(wakePulse), .ambientStart(ambStart),
    .proxStart(proxStart));
  sensor_link_checker i_sensor_link_checker (.clk(clk), .rstn(rstn), .regWe(link.regWe),
    .regRe(link.regRe), .regAddr(link.regAddr), .regWdata(link.regWdata),
    .regRdata(link.regRdata), .regRvalid(link.regRvalid), .irqO(link.irqO),
    .irqOe(link.irqOe), .irqLevel(link.irqLevel));

  initial forever #12.5 clk = ~clk;

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1;
    w = 1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (aw || w) begin
      @(posedge clk);
      if (awready) aw = 0;
      if (wready) w = 0;
      awvalid <= aw;
      wvalid <= w;
    end
    do @(posedge clk); while (!bvalid);
    check("write resp", bresp, er);
    bready <= 0;
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v,
    input logic [1:0] er, output logic [31:0] d);
    expq.push_back(exp_t'{m, v, er});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    rready <= 0;
    @(posedge clk);
  endtask : axi_read

  task automatic dev_cmd(input logic wr, input logic [7:0] off, input logic [7:0] val);
    logic [31:0] st;
    axi_write(sensor_pkg::HOST_OFF_CMD, {15'h0, wr, off, val}, sensor_pkg::RESP_OKAY);
    st = '1;
    while (st[sensor_pkg::STAT_BUSY_BIT])
      axi_read(sensor_pkg::HOST_OFF_STATUS, 0, 0, sensor_pkg::RESP_OKAY, st);
  endtask : dev_cmd

  task automatic dev_rd(input logic [7:0] off, input logic [7:0] exp);
    logic [31:0] st;
    dev_cmd(0, off, 8'h00);
    axi_read(sensor_pkg::HOST_OFF_STATUS, 32'hff, {24'h0, exp}, sensor_pkg::RESP_OKAY, st);
  endtask : dev_rd

  task automatic ev(input logic rw, input logic pd, input logic [1:0] clr);
    respWr <= rw;
    p3Done <= pd;
    flagClear <= clr;
    @(posedge clk);
    respWr <= 0;
    p3Done <= 0;
    flagClear <= 0;
    @(posedge clk);
  endtask : ev

  // Read answer compare and wake event counting
  always @(posedge clk) begin
    if (rvalid && rready) begin
      if (expq.size() == 0) check("unexpected read", 0, 1);
      else begin
        head = expq.pop_front();
        check("read data", rdata & head.mask, head.val);
        check("read resp", rresp, head.resp);
      end
    end
    cycles <= cycles + 1;
    gap <= wakePulse ? 1 : gap + 1;
    if (wakePulse) lastGap <= gap;
    wakes <= wakes + int'(wakePulse);
    ambs <= ambs + int'(ambStart);
    proxs <= proxs + int'(proxStart);
    stray <= stray + int'((ambStart || proxStart) && !wakePulse);
    if (cycles == 80000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    logic [31:0] st;
    logic [7:0] v;
    int w0, a0, p0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    for (int i = 6; i <= 11; i++) dev_rd(8'(i), 8'h00);
    axi_write(4'h8, 0, sensor_pkg::RESP_SLVERR);
    axi_read(4'h8, '1, 0, sensor_pkg::RESP_SLVERR, st);
    $display("test reset values done");
    for (int i = 6; i <= 10; i++) begin
      lfsr = nextRand(lfsr);
      v = (i == 6) ? (lfsr[7:0] & 8'hf7) : (i == 8) ? (lfsr[7:0] | 8'h18) : lfsr[7:0];
      if (i == 7) v = sensor_pkg::KEY_VALUE;
      dev_cmd(1, 8'(i), v);
      dev_rd(8'(i), (i == 6) ? (v & 8'h0f) : v);
    end
    check("unlocked", unlocked, 1);
    dev_cmd(1, sensor_pkg::OFF_WAKE, 8'h00);
    check("osc off", oscRunning, 0);
    $display("test readback done");
    cmdIe <= 1;
    intOe <= 1;
    for (int m = 0; m < 2; m++) for (int e = 0; e < 2; e++) begin
      dev_cmd(1, sensor_pkg::OFF_IRQ_MODE, 8'(m << sensor_pkg::CMD_MODE_LSB));
      respData <= {e[0], 7'h15};
      ev(1, 0, 2'b00);
      check("cmd flag", cmdFlag, m == 0 || e == 1);
      check("int pin", link.irqLevel, !(m == 0 || e == 1));
      if (m == 0) axi_read(sensor_pkg::HOST_OFF_STATUS, IRQ_M, IRQ_M, 2'h0, st);
      ev(0, 0, 2'b01);
    end
    cmdIe <= 0;
    ev(1, 0, 2'b00);
    check("cmd flag off", cmdFlag, 0);
    intOe <= 0;
    ev(0, 0, 2'b01);
    $display("test command interrupt done");
    p3Ie <= 1;
    intOe <= 1;
    foreach (p3Tab[i]) begin
      dev_cmd(1, sensor_pkg::OFF_IRQ_MODE, {6'h0, p3Tab[i][17:16]});
      p3Value <= p3Tab[i][15:0];
      ev(0, 1, 2'b00);
      check("prox3 flag", p3Flag, p3Tab[i][18]);
      ev(0, 0, 2'b10);
    end
    $display("test prox3 interrupt done");
    // Expansion seen through the device's own rate registers
    foreach (expTab[i]) begin
      dev_cmd(1, sensor_pkg::OFF_AMB, expTab[i][23:16]);
      check("amb expansion", i_sensor_regs_dev.ambValue, expTab[i][15:0]);
      if (expTab[i][23:16] != 8'h08) begin
        dev_cmd(1, sensor_pkg::OFF_WAKE, expTab[i][23:16]);
        check("wake expansion", i_sensor_regs_dev.wakeValue, expTab[i][15:0]);
      end
    end
    dev_cmd(1, sensor_pkg::OFF_WAKE, 8'h00);
    dev_cmd(1, sensor_pkg::OFF_AMB, 8'h08);
    dev_cmd(1, sensor_pkg::OFF_PROX, sensor_pkg::LOW_EXP_CODE);
    dev_cmd(1, sensor_pkg::OFF_WAKE, 8'h18);
    w0 = wakes;
    a0 = ambs;
    p0 = proxs;
    while (wakes < w0 + 10) @(posedge clk);
    check("wake gap", lastGap, 3 * sensor_pkg::TICK_CYCLES);
    check("ambient runs", ambs - a0, 10);
    check("prox runs", proxs - p0, 1);
    dev_cmd(1, sensor_pkg::OFF_AMB, sensor_pkg::RATE_OFF);
    dev_cmd(1, sensor_pkg::OFF_PROX, sensor_pkg::RATE_OFF);
    w0 = wakes;
    a0 = ambs;
    p0 = proxs;
    while (wakes < w0 + 2) @(posedge clk);
    check("ambient off", ambs - a0, 0);
    check("prox off", proxs - p0, 0);
    check("stray start", stray, 0);
    dev_cmd(1, sensor_pkg::OFF_WAKE, 8'h00);
    w0 = wakes;
    repeat (4000) @(posedge clk);
    check("no wake", wakes - w0, 0);
    $display("test wake rates done");
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    dev_rd(sensor_pkg::OFF_KEY, 8'h00);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
